// File: sw_pkg.sv
// shared constants and types of the switch control register bank
// Behaviour
// R1 - parallel pins load the parallel-side settings
// R2 - after reset, pins control until serial event
// R3 - serial event swaps in serial values, locks pins
// R4 - serial values start at register defaults
// R5 - serial slave reads and writes every register
// R6 - three straps give low slave address bits
// R7 - fast modes: enable, mode, source; reset 0x40
// R8 - side modes: enable, mode, source; reset 0x40
// R9 - receiver termination bit, resets set
// R10 - sixteen pulse select bits over two registers
// R11 - transmitter preemphasis, termination, current fields
// R12 - empty bits read zero; unknown addresses inert
// R13 - fast enable clear means standby, set on
// R14 - fast mode 11 rejected, value kept
// R15 - side mode 11 rejected, value kept
// R16 - host sends fixed upper four address bits
`default_nettype none
package sw_pkg;
	// register offsets
	localparam logic [7:0] OFF_FAST_MODES = 8'h00;
	localparam logic [7:0] OFF_SIDE_MODES = 8'h01;
	localparam logic [7:0] OFF_IN_SET     = 8'h10;
	localparam logic [7:0] OFF_PULSE_LO   = 8'h11;
	localparam logic [7:0] OFF_PULSE_HI   = 8'h12;
	localparam logic [7:0] OFF_EQUAL_LO   = 8'h13;
	localparam logic [7:0] OFF_EQUAL_HI   = 8'h14;
	localparam logic [7:0] OFF_OUT_SET    = 8'h20;
	// reset values
	localparam logic [7:0] RST_FAST_MODES = 8'h40;
	localparam logic [7:0] RST_SIDE_MODES = 8'h40;
	localparam logic [7:0] RST_IN_SET     = 8'h01;
	localparam logic [7:0] RST_PULSE_LO   = 8'h00;
	localparam logic [7:0] RST_PULSE_HI   = 8'h00;
	localparam logic [7:0] RST_EQUAL_LO   = 8'h00;
	localparam logic [7:0] RST_EQUAL_HI   = 8'h00;
	localparam logic [7:0] RST_OUT_SET    = 8'h03;
	// field positions inside a register byte
	localparam int POS_ON       = 6;
	localparam int POS_MODE     = 4;
	localparam int POS_SRC      = 0;
	localparam int POS_IN_TERM  = 0;
	localparam int POS_PREEMPH  = 2;
	localparam int POS_OUT_TERM = 1;
	localparam int POS_OUT_CUR  = 0;
	// mode codes
	localparam logic [1:0] MODE_QUAD    = 2'h0;
	localparam logic [1:0] MODE_ILLEGAL = 2'h3;
	// fixed upper slave address bits and bits per byte
	localparam logic [3:0] ADDR_FIXED = 4'h9;
	localparam logic [3:0] BYTE_BITS  = 4'h8;
	// serial engine states, gray along the write path; ACK to TX flips two bits
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_DEV  = 3'h1,
		ST_ACK  = 3'h3,
		ST_RX   = 3'h2,
		ST_TX   = 3'h6,
		ST_TACK = 3'h7
	} sw_i2c_e;
	// one full set of switch settings
	typedef struct packed {
		logic        fast_switch_on;
		logic [1:0]  fast_switch_mode;
		logic [3:0]  fast_source_select;
		logic        side_switch_on;
		logic [1:0]  side_switch_mode;
		logic [3:0]  side_source_select;
		logic        input_termination_select;
		logic [15:0] termination_pulse_select;
		logic [15:0] input_equalizer_level;
		logic [1:0]  output_preemphasis_level;
		logic        output_termination_select;
		logic        output_current_level;
	} sw_cfg_s;
	// settings equal to the register defaults
	localparam sw_cfg_s CFG_RST = '{
		fast_switch_on:            RST_FAST_MODES[POS_ON],
		fast_switch_mode:          RST_FAST_MODES[POS_MODE +: 2],
		fast_source_select:        RST_FAST_MODES[POS_SRC +: 4],
		side_switch_on:            RST_SIDE_MODES[POS_ON],
		side_switch_mode:          RST_SIDE_MODES[POS_MODE +: 2],
		side_source_select:        RST_SIDE_MODES[POS_SRC +: 4],
		input_termination_select:  RST_IN_SET[POS_IN_TERM],
		termination_pulse_select:  {RST_PULSE_HI, RST_PULSE_LO},
		input_equalizer_level:     {RST_EQUAL_HI, RST_EQUAL_LO},
		output_preemphasis_level:  RST_OUT_SET[POS_PREEMPH +: 2],
		output_termination_select: RST_OUT_SET[POS_OUT_TERM],
		output_current_level:      RST_OUT_SET[POS_OUT_CUR]
	};
endpackage : sw_pkg
`default_nettype wire

// File: sw_bus_if.sv
// byte carrier between the serial engine and the register bank
`timescale 1ns/1ns
`default_nettype none
interface sw_bus_if;
	logic       hit;      // own address acknowledged, pulse
	logic       rx_stb;   // written byte complete, pulse
	logic       rx_first; // byte is the register pointer
	logic [7:0] rx_data;  // written byte
	logic       tx_stb;   // read byte taken, pulse
	logic [7:0] tx_data;  // byte at the pointer
	modport engine (output hit, rx_stb, rx_first, rx_data, tx_stb,
		input tx_data);
	modport bank (input hit, rx_stb, rx_first, rx_data, tx_stb,
		output tx_data);
endinterface : sw_bus_if
`default_nettype wire

// File: sw_sync.sv
// two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module sw_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	// first stage feeds only the second stage
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] safe;
	} sw_sync_s;

	sw_sync_s r_q;
	sw_sync_s r_d;

	// shift both stages
	always_comb
	begin
		r_d.meta = async_in;
		r_d.safe = r_q.meta;
	end

	// register with constant reset
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			r_q <= '0;
		else
			r_q <= r_d;
	end

	assign sync_out = r_q.safe;
endmodule : sw_sync
`default_nettype wire

// File: sw_i2c.sv
// two-wire serial slave engine, oversampled on the system clock
`timescale 1ns/1ns
`default_nettype none
module sw_i2c (
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic       scl_s,
	input  wire logic       sda_s,
	input  wire logic [2:0] addr_low,
	sw_bus_if.engine        bus,
	output logic            sda_oe
);
	typedef struct packed {
		logic           scl_p; // previous clock level
		logic           sda_p; // previous data level
		sw_pkg::sw_i2c_e st;
		logic [3:0]     cnt;   // bits moved in this byte
		logic [7:0]     sh;    // shift register
		logic           rw;    // read transfer
		logic           drv;   // pull data low
		logic           first; // next byte is pointer
		logic           hit;
		logic           rx_stb;
		logic           tx_stb;
	} sw_i2c_s;

	sw_i2c_s r_q;
	sw_i2c_s r_d;
	logic    rise;
	logic    fall;
	logic    start;
	logic    stop;

	// line events and byte sequencing
	always_comb
	begin
		r_d = r_q;
		r_d.hit = 1'b0;
		r_d.rx_stb = 1'b0;
		r_d.tx_stb = 1'b0;
		r_d.scl_p = scl_s;
		r_d.sda_p = sda_s;
		rise = scl_s & ~r_q.scl_p;
		fall = ~scl_s & r_q.scl_p;
		start = scl_s & r_q.scl_p & r_q.sda_p & ~sda_s;
		stop = scl_s & r_q.scl_p & ~r_q.sda_p & sda_s;
		// pointer flag drops once its byte was handed over
		if (r_q.rx_stb)
			r_d.first = 1'b0;
		if (start)
		begin
			r_d.st = sw_pkg::ST_DEV;
			r_d.cnt = 4'h0;
			r_d.drv = 1'b0;
		end
		else if (stop)
		begin
			r_d.st = sw_pkg::ST_IDLE;
			r_d.drv = 1'b0;
		end
		else
		begin
			unique case (r_q.st)
				sw_pkg::ST_IDLE: ;
				sw_pkg::ST_DEV, sw_pkg::ST_RX:
				begin
					if (rise)
					begin
						r_d.sh = {r_q.sh[6:0], sda_s};
						r_d.cnt = r_q.cnt + 4'h1;
					end
					else if (fall && r_q.cnt == sw_pkg::BYTE_BITS)
					begin
						if (r_q.st == sw_pkg::ST_RX)
						begin
							r_d.rx_stb = 1'b1; // R5
							r_d.drv = 1'b1;
							r_d.st = sw_pkg::ST_ACK;
						end
						else if (r_q.sh[7:1] == {sw_pkg::ADDR_FIXED,
							addr_low}) // R6
						begin
							r_d.hit = 1'b1;
							r_d.rw = r_q.sh[0];
							r_d.first = ~r_q.sh[0];
							r_d.drv = 1'b1;
							r_d.st = sw_pkg::ST_ACK;
						end
						else
							r_d.st = sw_pkg::ST_IDLE;
					end
				end
				sw_pkg::ST_ACK, sw_pkg::ST_TACK:
				begin
					// a not-acknowledge ends a read
					if (r_q.st == sw_pkg::ST_TACK && rise && sda_s)
						r_d.st = sw_pkg::ST_IDLE;
					else if (fall && (r_q.rw || r_q.st == sw_pkg::ST_TACK))
					begin
						r_d.sh = bus.tx_data; // R5
						r_d.drv = ~bus.tx_data[7];
						r_d.cnt = 4'h1;
						r_d.tx_stb = 1'b1;
						r_d.st = sw_pkg::ST_TX;
					end
					else if (fall)
					begin
						r_d.drv = 1'b0;
						r_d.cnt = 4'h0;
						r_d.st = sw_pkg::ST_RX;
					end
				end
				sw_pkg::ST_TX:
				begin
					if (fall && r_q.cnt == sw_pkg::BYTE_BITS)
					begin
						r_d.drv = 1'b0;
						r_d.st = sw_pkg::ST_TACK;
					end
					else if (fall)
					begin
						r_d.sh = {r_q.sh[6:0], 1'b0};
						r_d.drv = ~r_q.sh[6];
						r_d.cnt = r_q.cnt + 4'h1;
					end
				end
				// unused codes fall back to idle
				default:
				begin
					r_d.st = sw_pkg::ST_IDLE;
					r_d.drv = 1'b0;
				end
			endcase
		end
	end

	// idle lines are high, so reset mimics them
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			r_q <= '{scl_p: 1'b1, sda_p: 1'b1, st: sw_pkg::ST_IDLE,
				default: '0};
		else
			r_q <= r_d;
	end

	assign sda_oe = r_q.drv;
	assign bus.hit = r_q.hit;
	assign bus.rx_stb = r_q.rx_stb;
	assign bus.rx_first = r_q.first;
	assign bus.rx_data = r_q.sh;
	assign bus.tx_stb = r_q.tx_stb;
endmodule : sw_i2c
`default_nettype wire

// File: sw_ctrl_bank.sv
// switch control register bank with parallel pins and serial slave
`timescale 1ns/1ns
`default_nettype none
module sw_ctrl_bank (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// serial bus pins, data is open drain
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// low slave address straps
	input  wire logic        slave_addr_strap_2,
	input  wire logic        slave_addr_strap_1,
	input  wire logic        slave_addr_strap_0,
	// parallel control pins
	input  wire logic        pin_switch_on,
	input  wire logic [1:0]  pin_source_select,
	input  wire logic        pin_equalizer_level,
	input  wire logic [1:0]  pin_preemphasis_level,
	input  wire logic        pin_output_termination,
	input  wire logic        pin_output_current,
	// settings toward the analog switch
	output logic             fast_switch_on,
	output logic [1:0]       fast_switch_mode,
	output logic [3:0]       fast_source_select,
	output logic             side_switch_on,
	output logic [1:0]       side_switch_mode,
	output logic [3:0]       side_source_select,
	output logic             input_termination_select,
	output logic [15:0]      termination_pulse_select,
	output logic [15:0]      input_equalizer_level,
	output logic [1:0]       output_preemphasis_level,
	output logic             output_termination_select,
	output logic             output_current_level,
	output logic             serial_control_active
);
	// whole state of the bank
	typedef struct packed {
		logic            ser;  // serial control owns settings
		logic [7:0]      ptr;  // register pointer
		sw_pkg::sw_cfg_s regs; // serial register values
		sw_pkg::sw_cfg_s eff;  // settings driven out
	} sw_bank_s;

	sw_bank_s        r_q;
	sw_bank_s        r_d;
	sw_pkg::sw_cfg_s pin_cfg;  // settings implied by the pins
	logic [12:0]     pins_s;   // synchronised pins
	logic            scl_s;
	logic            sda_s;
	logic [2:0]      strap_s;
	logic            p_on;
	logic [1:0]      p_src;
	logic            p_eq;
	logic [1:0]      p_pre;
	logic            p_oterm;
	logic            p_ocur;

	sw_bus_if bus ();

	// every pin is asynchronous to mclk
	sw_sync #(
		.W (13)
	) u_sync (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.async_in ({scl_in, sda_in, slave_addr_strap_2,
			slave_addr_strap_1, slave_addr_strap_0, pin_switch_on,
			pin_source_select, pin_equalizer_level,
			pin_preemphasis_level, pin_output_termination,
			pin_output_current}),
		.sync_out (pins_s)
	);

	assign {scl_s, sda_s, strap_s, p_on, p_src, p_eq, p_pre, p_oterm,
		p_ocur} = pins_s;

	// serial slave engine
	sw_i2c u_i2c (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.scl_s    (scl_s),
		.sda_s    (sda_s),
		.addr_low (strap_s),
		.bus      (bus),
		.sda_oe   (sda_oe)
	);

	// write one byte; illegal modes keep the old field
	function automatic sw_pkg::sw_cfg_s wr_reg(sw_pkg::sw_cfg_s c,
		logic [7:0] a, logic [7:0] d);
		sw_pkg::sw_cfg_s n;
		n = c;
		unique case (a)
			sw_pkg::OFF_FAST_MODES:
			begin
				n.fast_switch_on = d[sw_pkg::POS_ON]; // R7
				if (d[sw_pkg::POS_MODE +: 2] != sw_pkg::MODE_ILLEGAL)
					n.fast_switch_mode = d[sw_pkg::POS_MODE +: 2]; // R14
				n.fast_source_select = d[sw_pkg::POS_SRC +: 4];
			end
			sw_pkg::OFF_SIDE_MODES:
			begin
				n.side_switch_on = d[sw_pkg::POS_ON]; // R8
				if (d[sw_pkg::POS_MODE +: 2] != sw_pkg::MODE_ILLEGAL)
					n.side_switch_mode = d[sw_pkg::POS_MODE +: 2]; // R15
				n.side_source_select = d[sw_pkg::POS_SRC +: 4];
			end
			sw_pkg::OFF_IN_SET:
				n.input_termination_select = d[sw_pkg::POS_IN_TERM]; // R9
			sw_pkg::OFF_PULSE_LO:
				n.termination_pulse_select[7:0] = d; // R10
			sw_pkg::OFF_PULSE_HI:
				n.termination_pulse_select[15:8] = d; // R10
			sw_pkg::OFF_EQUAL_LO:
				n.input_equalizer_level[7:0] = d;
			sw_pkg::OFF_EQUAL_HI:
				n.input_equalizer_level[15:8] = d;
			sw_pkg::OFF_OUT_SET:
			begin
				n.output_preemphasis_level = d[sw_pkg::POS_PREEMPH +: 2]; // R11
				n.output_termination_select = d[sw_pkg::POS_OUT_TERM];
				n.output_current_level = d[sw_pkg::POS_OUT_CUR];
			end
			// unknown offsets change nothing
			default: ; // R12
		endcase
		return n;
	endfunction : wr_reg

	// read one byte; empty bits and unknown offsets read zero
	function automatic logic [7:0] rd_reg(sw_pkg::sw_cfg_s c,
		logic [7:0] a);
		logic [7:0] d;
		d = 8'h00; // R12
		unique case (a)
			sw_pkg::OFF_FAST_MODES:
			begin
				d[sw_pkg::POS_ON] = c.fast_switch_on;
				d[sw_pkg::POS_MODE +: 2] = c.fast_switch_mode;
				d[sw_pkg::POS_SRC +: 4] = c.fast_source_select;
			end
			sw_pkg::OFF_SIDE_MODES:
			begin
				d[sw_pkg::POS_ON] = c.side_switch_on;
				d[sw_pkg::POS_MODE +: 2] = c.side_switch_mode;
				d[sw_pkg::POS_SRC +: 4] = c.side_source_select;
			end
			sw_pkg::OFF_IN_SET:
				d[sw_pkg::POS_IN_TERM] = c.input_termination_select;
			sw_pkg::OFF_PULSE_LO:
				d = c.termination_pulse_select[7:0];
			sw_pkg::OFF_PULSE_HI:
				d = c.termination_pulse_select[15:8];
			sw_pkg::OFF_EQUAL_LO:
				d = c.input_equalizer_level[7:0];
			sw_pkg::OFF_EQUAL_HI:
				d = c.input_equalizer_level[15:8];
			sw_pkg::OFF_OUT_SET:
			begin
				d[sw_pkg::POS_PREEMPH +: 2] = c.output_preemphasis_level;
				d[sw_pkg::POS_OUT_TERM] = c.output_termination_select;
				d[sw_pkg::POS_OUT_CUR] = c.output_current_level;
			end
			default: ;
		endcase
		return d;
	endfunction : rd_reg

	// pins only reach quad mode; one level fans out to all channels
	always_comb
	begin
		pin_cfg = sw_pkg::CFG_RST; // R1
		pin_cfg.fast_switch_on = p_on;
		pin_cfg.fast_switch_mode = sw_pkg::MODE_QUAD;
		pin_cfg.fast_source_select = {2'h0, p_src};
		pin_cfg.side_switch_on = p_on;
		pin_cfg.side_switch_mode = sw_pkg::MODE_QUAD;
		pin_cfg.side_source_select = {2'h0, p_src};
		pin_cfg.input_equalizer_level = {16{p_eq}};
		pin_cfg.output_preemphasis_level = p_pre;
		pin_cfg.output_termination_select = p_oterm;
		pin_cfg.output_current_level = p_ocur;
	end

	// takeover, pointer and register updates
	always_comb
	begin
		r_d = r_q;
		// the first own-address hit locks the pins out
		if (bus.hit)
			r_d.ser = 1'b1; // R3
		// writes only land once serial control owns the bank
		if (bus.rx_stb && r_q.ser)
		begin
			if (bus.rx_first)
				r_d.ptr = bus.rx_data;
			else
			begin
				r_d.regs = wr_reg(r_q.regs, r_q.ptr, bus.rx_data); // R5
				r_d.ptr = r_q.ptr + 8'h01;
			end
		end
		// reads advance the pointer too
		if (bus.tx_stb)
			r_d.ptr = r_q.ptr + 8'h01;
		// pins steer until serial control, then registers
		r_d.eff = r_q.ser ? r_q.regs : pin_cfg; // R2 R3 R4
	end

	// single state register; regs start at their defaults
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			r_q <= '{ser: 1'b0, ptr: 8'h00, regs: sw_pkg::CFG_RST,
				eff: sw_pkg::CFG_RST};
		else
			r_q <= r_d;
	end

	// read data is a mux of flops; the engine samples it at a fall
	assign bus.tx_data = rd_reg(r_q.regs, r_q.ptr);

	// outputs straight from the settings flops
	assign fast_switch_on = r_q.eff.fast_switch_on; // R13
	assign fast_switch_mode = r_q.eff.fast_switch_mode;
	assign fast_source_select = r_q.eff.fast_source_select;
	assign side_switch_on = r_q.eff.side_switch_on;
	assign side_switch_mode = r_q.eff.side_switch_mode;
	assign side_source_select = r_q.eff.side_source_select;
	assign input_termination_select = r_q.eff.input_termination_select;
	assign termination_pulse_select = r_q.eff.termination_pulse_select;
	assign input_equalizer_level = r_q.eff.input_equalizer_level;
	assign output_preemphasis_level = r_q.eff.output_preemphasis_level;
	assign output_termination_select =
		r_q.eff.output_termination_select;
	assign output_current_level = r_q.eff.output_current_level;
	assign serial_control_active = r_q.ser;
	// open drain: only ever pulls low
	assign sda_out = 1'b0;

	// checks, all in the mclk domain
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	logic wr_data;  // a data byte write lands this cycle
	assign wr_data = bus.rx_stb && !bus.rx_first && r_q.ser;

	// the release edge still shows defaults, so skip it
	property p_pins_follow;
		$past(rst_b) && !r_q.ser |=> fast_switch_on == $past(p_on)
			&& output_preemphasis_level == $past(p_pre);
	endproperty
	a_pins_follow: assert property (p_pins_follow) // R1
		else $error("settings do not follow pins");

	property p_stay_parallel;
		!r_q.ser && !bus.hit |=> !serial_control_active;
	endproperty
	a_stay_parallel: assert property (p_stay_parallel) // R2
		else $error("serial control without address hit");

	property p_takeover;
		bus.hit |=> serial_control_active ##1
			(r_q.eff == $past(r_q.regs));
	endproperty
	a_takeover: assert property (p_takeover) // R3
		else $error("takeover did not switch settings");

	property p_locked;
		serial_control_active |=> serial_control_active;
	endproperty
	a_locked: assert property (p_locked) // R3
		else $error("serial control released before reset");

	property p_defaults;
		!r_q.ser |-> r_q.regs == sw_pkg::CFG_RST;
	endproperty
	a_defaults: assert property (p_defaults) // R4
		else $error("serial values moved before takeover");

	property p_pulse_write;
		wr_data && r_q.ptr == sw_pkg::OFF_PULSE_HI |=>
			r_q.regs.termination_pulse_select[15:8] == $past(bus.rx_data);
	endproperty
	a_pulse_write: assert property (p_pulse_write) // R10
		else $error("pulse high byte not written");

	property p_out_write;
		wr_data && r_q.ptr == sw_pkg::OFF_OUT_SET |=> ##1
			output_preemphasis_level == $past(bus.rx_data[3:2], 2);
	endproperty
	a_out_write: assert property (p_out_write) // R11
		else $error("preemphasis field not written");

	property p_unknown_inert;
		wr_data && rd_reg(sw_pkg::CFG_RST, r_q.ptr) == 8'h00
			&& r_q.ptr > sw_pkg::OFF_OUT_SET |=> $stable(r_q.regs);
	endproperty
	a_unknown_inert: assert property (p_unknown_inert) // R12
		else $error("unknown offset changed a setting");

	property p_fast_illegal;
		wr_data && r_q.ptr == sw_pkg::OFF_FAST_MODES
			&& bus.rx_data[5:4] == sw_pkg::MODE_ILLEGAL
			|=> $stable(r_q.regs.fast_switch_mode);
	endproperty
	a_fast_illegal: assert property (p_fast_illegal) // R14
		else $error("illegal fast mode accepted");

	property p_side_illegal;
		wr_data && r_q.ptr == sw_pkg::OFF_SIDE_MODES
			&& bus.rx_data[5:4] == sw_pkg::MODE_ILLEGAL
			|=> $stable(r_q.regs.side_switch_mode);
	endproperty
	a_side_illegal: assert property (p_side_illegal) // R15
		else $error("illegal side mode accepted");

	property p_standby;
		r_q.ser && !r_q.regs.fast_switch_on |=> !fast_switch_on;
	endproperty
	a_standby: assert property (p_standby) // R13
		else $error("fast switch not in standby");

	property p_cov_hit;
		!r_q.ser ##1 bus.hit;
	endproperty
	c_cov_hit: cover property (p_cov_hit);

	property p_cov_write;
		wr_data && r_q.ptr == sw_pkg::OFF_FAST_MODES;
	endproperty
	c_cov_write: cover property (p_cov_write);

	property p_cov_read;
		r_q.ser && bus.tx_stb;
	endproperty
	c_cov_read: cover property (p_cov_read);
endmodule : sw_ctrl_bank
`default_nettype wire

// File: sw_host.sv
// bus master model driving the bank's serial pins
`timescale 1ns/1ns
`default_nettype none
module sw_host (
	input  wire logic mclk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_drv
);
	// released lines idle high
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// one bit; low phase kept well over six clocks
	task automatic bit_io(input logic b, output logic s);
		sda_drv <= b;
		repeat (5) @(posedge mclk);
		scl <= 1'b1;
		repeat (5) @(posedge mclk);
		s = sda_line;
		repeat (5) @(posedge mclk);
		scl <= 1'b0;
		repeat (5) @(posedge mclk);
	endtask : bit_io
	// start or repeated start: data falls while clock high
	task automatic start();
		sda_drv <= 1'b1;
		repeat (5) @(posedge mclk);
		scl <= 1'b1;
		repeat (9) @(posedge mclk);
		sda_drv <= 1'b0;
		repeat (9) @(posedge mclk);
		scl <= 1'b0;
		repeat (5) @(posedge mclk);
	endtask : start
	// stop: data rises while clock high, bus left idle
	task automatic stop();
		sda_drv <= 1'b0;
		repeat (5) @(posedge mclk);
		scl <= 1'b1;
		repeat (9) @(posedge mclk);
		sda_drv <= 1'b1;
		repeat (9) @(posedge mclk);
	endtask : stop
	// byte out msb first, then the device's answer bit
	task automatic put(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask : put
	// byte in msb first; a release on the last ends the read
	task automatic get(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(last, s);
	endtask : get
endmodule : sw_host
`default_nettype wire

// File: tb_top.sv
// self-checking bench of the switch control register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam logic [7:0] OFFS [10] = '{8'h00, 8'h01, 8'h10, 8'h11,
		8'h12, 8'h13, 8'h14, 8'h20, 8'h05, 8'h21};
	logic                 mclk;        // system clock
	logic                 rst_b;       // async reset
	logic [7:0]           pins;        // parallel pin levels
	logic [2:0]           strap;       // address straps
	logic                 ser;         // model: serial took over
	logic [7:0]           mreg [256];  // model register map
	logic [31:0]          rng;         // xorshift state
	logic [7:0]           v;           // value to write
	int                   n_fail;      // mismatches
	int                   check_count; // comparisons
	wire logic            scl, sda_drv, sda_out, sda_oe, sca;
	wire logic            sda_w;       // data line, pulled up
	wire sw_pkg::sw_cfg_s got;         // settings at the pins
	// open drain: only a low pull wins over the pull-up
	assign sda_w = sda_drv & ~(sda_oe & ~sda_out);
	// 20 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	sw_host host (.mclk(mclk), .sda_line(sda_w), .scl(scl),
		.sda_drv(sda_drv));
	sw_ctrl_bank dut (.mclk(mclk), .rst_b(rst_b), .scl_in(scl),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
		.slave_addr_strap_2(strap[2]), .slave_addr_strap_1(strap[1]),
		.slave_addr_strap_0(strap[0]), .pin_switch_on(pins[7]),
		.pin_source_select(pins[6:5]), .pin_equalizer_level(pins[4]),
		.pin_preemphasis_level(pins[3:2]),
		.pin_output_termination(pins[1]), .pin_output_current(pins[0]),
		.fast_switch_on(got.fast_switch_on),
		.fast_switch_mode(got.fast_switch_mode),
		.fast_source_select(got.fast_source_select),
		.side_switch_on(got.side_switch_on),
		.side_switch_mode(got.side_switch_mode),
		.side_source_select(got.side_source_select),
		.input_termination_select(got.input_termination_select),
		.termination_pulse_select(got.termination_pulse_select),
		.input_equalizer_level(got.input_equalizer_level),
		.output_preemphasis_level(got.output_preemphasis_level),
		.output_termination_select(got.output_termination_select),
		.output_current_level(got.output_current_level),
		.serial_control_active(sca));
	// fixed-seed pseudo random bytes
	function automatic logic [7:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[7:0];
	endfunction : xs
	// model back to defaults, pins in charge
	task automatic mreset();
		foreach (mreg[i])
			mreg[i] = 8'h00;
		mreg[8'h00] = 8'h40;
		mreg[8'h01] = 8'h40;
		mreg[8'h10] = 8'h01;
		mreg[8'h20] = 8'h03;
		ser = 1'b0;
	endtask : mreset
	// model write: empty bits dropped, mode 11 keeps old mode
	task automatic mwr(input logic [7:0] a, input logic [7:0] d);
		case (a)
			8'h00, 8'h01: mreg[a] = {1'b0, d[6], (d[5:4] == 2'h3) ?
				mreg[a][5:4] : d[5:4], d[3:0]};
			8'h10: mreg[a] = {7'h0, d[0]};
			8'h11, 8'h12, 8'h13, 8'h14: mreg[a] = d;
			8'h20: mreg[a] = {4'h0, d[3:0]};
			default: ;
		endcase
	endtask : mwr
	// expected settings from pins or from the model map
	function automatic sw_pkg::sw_cfg_s exp_cfg();
		if (!ser)
			return {pins[7], 4'h0, pins[6:5], pins[7], 4'h0, pins[6:5],
				1'b1, 16'h0, {16{pins[4]}}, pins[3:0]};
		return {mreg[0][6:0], mreg[1][6:0], mreg[16][0], mreg[18],
			mreg[17], mreg[20], mreg[19], mreg[32][3:0]};
	endfunction : exp_cfg
	// count a comparison, report a mismatch
	task automatic judge(input logic ok, input logic [63:0] g, e);
		check_count++;
		if (!ok)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : judge
	task automatic chk_bit(input logic g, input logic e);
		judge(g === e, 64'(g), 64'(e));
	endtask : chk_bit
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		judge(g === e, 64'(g), 64'(e));
	endtask : chk_byte
	// settings sampled away from the clock edge
	task automatic chk_cfg();
		@(negedge mclk);
		judge(got === exp_cfg(), 64'(got), 64'(exp_cfg()));
	endtask : chk_cfg
	// random pin levels, settings follow or stay locked
	task automatic pins_track();
		repeat (4)
		begin
			@(posedge mclk);
			pins <= xs();
			repeat (4) @(posedge mclk);
			chk_cfg();
		end
	endtask : pins_track
	// address byte that must go unanswered
	task automatic bad_addr(input logic [6:0] a);
		logic k;
		host.start();
		host.put({a, 1'b0}, k);
		host.stop();
		chk_bit(k, 1'b0);
		chk_bit(sca, 1'b0);
	endtask : bad_addr
	// pointer then one data byte
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		logic k;
		host.start();
		host.put({sw_pkg::ADDR_FIXED, strap, 1'b0}, k);
		chk_bit(k, 1'b1);
		ser = 1'b1;
		host.put(a, k);
		host.put(d, k);
		host.stop();
		mwr(a, d);
	endtask : wr_reg
	// pointer, repeated start, one byte back
	task automatic rd_reg(input logic [7:0] a);
		logic       k;
		logic [7:0] d;
		host.start();
		host.put({sw_pkg::ADDR_FIXED, strap, 1'b0}, k);
		host.put(a, k);
		host.start();
		host.put({sw_pkg::ADDR_FIXED, strap, 1'b1}, k);
		host.get(1'b1, d);
		host.stop();
		chk_byte(d, mreg[a]);
	endtask : rd_reg
	// single place where the run ends
	task automatic print_verdict();
		if (n_fail == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	// hang guard, well above the expected run length
	initial
	begin
		repeat (90000) @(posedge mclk);
		n_fail++;
		print_verdict();
	end
	// main sequence
	initial
	begin
		rng = 32'h4;
		n_fail = 0;
		check_count = 0;
		rst_b <= 1'b0;
		pins <= 8'h00;
		strap <= 3'(xs());
		mreset();
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		pins_track();
		bad_addr({4'h1, strap});
		bad_addr({sw_pkg::ADDR_FIXED, strap ^ 3'h2});
		pins_track();
		// first serial event hits an empty offset
		wr_reg(8'h05, xs());
		pins_track();
		chk_bit(sca, 1'b1);
		foreach (OFFS[i])
			rd_reg(OFFS[i]);
		// every mode code in every byte, incl. the illegal one
		for (int r = 0; r < 4; r++)
			foreach (OFFS[i])
			begin
				v = xs();
				v[5:4] = 2'(r);
				wr_reg(OFFS[i], v);
				rd_reg(OFFS[i]);
				chk_cfg();
			end
		// second reset hands control back to the pins
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		mreset();
		pins_track();
		chk_bit(sca, 1'b0);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
